//--- shared/cfg_load_pkg.sv
// Shared constants, types and pin bundles for the test-port configuration loader.
package cfg_load_pkg;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int        IR_W          = 4;
  localparam logic [3:0] OP_SAMPLE    = 4'h1;
  localparam logic [3:0] OP_IDCODE    = 4'h2;
  localparam logic [3:0] OP_PROGRAM   = 4'h3;
  localparam logic [3:0] OP_START     = 4'h4;
  localparam logic [3:0] OP_STATUS    = 4'h5;
  localparam logic [3:0] OP_IO_SETUP  = 4'h6;
  localparam logic [3:0] OP_RELOAD    = 4'h7;
  localparam logic [3:0] OP_BYPASS    = 4'hf;
  localparam logic [3:0] IR_CAPTURE   = 4'h1;

  // ----------------------------------------------------------------
  // Data registers and timing
  // ----------------------------------------------------------------
  localparam int         DR_W         = 32;
  localparam int         IO_W         = 16;
  localparam int         WORD_W       = 8;
  localparam int         FIFO_DEPTH   = 32;
  // Arbitrary identification value, names no real part.
  localparam logic [31:0] ID_VALUE    = 32'h0a5a_5001;
  // Extra test clocks needed after the last bitstream bit.
  localparam int         INIT_CYCLES  = 1094;
  localparam int         INIT_CNT_W   = 11;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic reload_request_low;
  } pin_sample_t;

endpackage

//--- logic/word_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } fifo_state_t;

  fifo_state_t    st_r;
  fifo_state_t    st_nxt;
  logic [W-1:0]   mem [DEPTH];
  logic           push;
  logic           pop;

  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = mem[st_r.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr = (st_r.wr == AW'(DEPTH-1)) ? '0 : st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = (st_r.rd == AW'(DEPTH-1)) ? '0 : st_r.rd + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem[st_r.wr] <= in_data;
    end
  end
endmodule

//--- logic/cfg_load_port.sv
// Test-port configuration loader: sampled TAP, instruction gating and bitstream intake.
`timescale 1ns/1ps

module cfg_load_port #(
  parameter int IO_W   = cfg_load_pkg::IO_W,
  parameter int WORD_W = cfg_load_pkg::WORD_W,
  parameter int DEPTH  = cfg_load_pkg::FIFO_DEPTH
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  input  wire logic              trst_n,
  input  wire logic              reload_request_low,
  input  wire logic              other_load_active,
  input  wire logic [IO_W-1:0]   io_pins_in,
  output logic                   tdo_out,
  output logic                   tdo_oe_n,
  output logic                   load_complete_flag,
  output logic                   user_io_hiz,
  output logic                   load_abort,
  output logic                   restart_load,
  output logic                   load_overrun,
  output logic [IO_W-1:0]        io_setup,
  output logic                   cfg_valid,
  input  wire logic              cfg_ready,
  output logic [WORD_W-1:0]      cfg_word
);
  localparam int BW = $clog2(WORD_W);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cfg_load_pkg::pin_sample_t   s1;
    cfg_load_pkg::pin_sample_t   s2;
    logic                        tck_d;
    logic                        reload_d;
    cfg_load_pkg::tap_state_t    tap;
    logic [cfg_load_pkg::IR_W-1:0] ir_sh;
    logic [cfg_load_pkg::IR_W-1:0] ir;
    logic [cfg_load_pkg::DR_W-1:0] dr_sh;
    logic                        bypass;
    logic [WORD_W-1:0]           word;
    logic [BW-1:0]               bits;
    logic                        pend;
    logic [WORD_W-1:0]           pend_data;
    logic                        loading;
    logic                        interrupted;
    logic [cfg_load_pkg::INIT_CNT_W-1:0] init_cnt;
    logic                        tdo;
    logic                        tdo_oe_n;
    logic                        done;
    logic                        abort;
    logic                        restart;
    logic                        overrun;
    logic [IO_W-1:0]             io_setup;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic        fifo_ready;

  word_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (st_r.pend),
    .in_ready  (fifo_ready),
    .in_data   (st_r.pend_data),
    .out_valid (cfg_valid),
    .out_ready (cfg_ready),
    .out_data  (cfg_word)
  );

  // ----------------------------------------------------------------
  // TAP next state
  // ----------------------------------------------------------------
  function automatic cfg_load_pkg::tap_state_t tap_next(cfg_load_pkg::tap_state_t s,
                                                        logic m);
    case (s)
      cfg_load_pkg::TLR:    tap_next = m ? cfg_load_pkg::TLR    : cfg_load_pkg::RTI;
      cfg_load_pkg::RTI:    tap_next = m ? cfg_load_pkg::SEL_DR : cfg_load_pkg::RTI;
      cfg_load_pkg::SEL_DR: tap_next = m ? cfg_load_pkg::SEL_IR : cfg_load_pkg::CAP_DR;
      cfg_load_pkg::CAP_DR: tap_next = m ? cfg_load_pkg::EX1_DR : cfg_load_pkg::SH_DR;
      cfg_load_pkg::SH_DR:  tap_next = m ? cfg_load_pkg::EX1_DR : cfg_load_pkg::SH_DR;
      cfg_load_pkg::EX1_DR: tap_next = m ? cfg_load_pkg::UPD_DR : cfg_load_pkg::PAU_DR;
      cfg_load_pkg::PAU_DR: tap_next = m ? cfg_load_pkg::EX2_DR : cfg_load_pkg::PAU_DR;
      cfg_load_pkg::EX2_DR: tap_next = m ? cfg_load_pkg::UPD_DR : cfg_load_pkg::SH_DR;
      cfg_load_pkg::UPD_DR: tap_next = m ? cfg_load_pkg::SEL_DR : cfg_load_pkg::RTI;
      cfg_load_pkg::SEL_IR: tap_next = m ? cfg_load_pkg::TLR    : cfg_load_pkg::CAP_IR;
      cfg_load_pkg::CAP_IR: tap_next = m ? cfg_load_pkg::EX1_IR : cfg_load_pkg::SH_IR;
      cfg_load_pkg::SH_IR:  tap_next = m ? cfg_load_pkg::EX1_IR : cfg_load_pkg::SH_IR;
      cfg_load_pkg::EX1_IR: tap_next = m ? cfg_load_pkg::UPD_IR : cfg_load_pkg::PAU_IR;
      cfg_load_pkg::PAU_IR: tap_next = m ? cfg_load_pkg::EX2_IR : cfg_load_pkg::PAU_IR;
      cfg_load_pkg::EX2_IR: tap_next = m ? cfg_load_pkg::UPD_IR : cfg_load_pkg::SH_IR;
      cfg_load_pkg::UPD_IR: tap_next = m ? cfg_load_pkg::SEL_DR : cfg_load_pkg::RTI;
      default:              tap_next = cfg_load_pkg::TLR;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sampled-clock behaviour
  // ----------------------------------------------------------------
  always_comb begin
    logic                         rise;
    logic                         fall;
    logic                         word_done;
    logic [cfg_load_pkg::IR_W-1:0] op;
    rise      = st_r.s2.tck & ~st_r.tck_d;
    fall      = ~st_r.s2.tck & st_r.tck_d;
    word_done = 1'b0;
    op        = st_r.ir;
    st_nxt    = st_r;
    // Pins cross two flops before anything else looks at them.
    st_nxt.s1       = {tck, tms, tdi, trst_n, reload_request_low};
    st_nxt.s2       = st_r.s1;
    st_nxt.tck_d    = st_r.s2.tck;
    st_nxt.reload_d = st_r.s2.reload_request_low;
    st_nxt.abort    = 1'b0;
    st_nxt.restart  = 1'b0;

    // limited instruction set
    // Until an I/O setup interrupts a running load, only non-disturbing
    // instructions, a takeover load and the reload restart act; anything else behaves as bypass.
    if (other_load_active && !st_r.interrupted &&
        op != cfg_load_pkg::OP_IDCODE && op != cfg_load_pkg::OP_SAMPLE &&
        op != cfg_load_pkg::OP_IO_SETUP && op != cfg_load_pkg::OP_PROGRAM) begin
      op = cfg_load_pkg::OP_BYPASS;
    end

    if (st_r.pend && fifo_ready) begin
      st_nxt.pend = 1'b0;
    end

    if (rise) begin
      st_nxt.tap = tap_next(st_r.tap, st_r.s2.tms);
      case (st_r.tap)
        cfg_load_pkg::TLR: begin
          st_nxt.ir = cfg_load_pkg::OP_IDCODE;
        end
        cfg_load_pkg::RTI: begin
          // Initialisation clocks only count while the start instruction is held.
          if (op == cfg_load_pkg::OP_START && st_r.loading) begin
            st_nxt.init_cnt = st_r.init_cnt + 1'b1;
            if (st_r.init_cnt == cfg_load_pkg::INIT_CNT_W'(cfg_load_pkg::INIT_CYCLES - 1)) begin
              st_nxt.done    = ~st_r.overrun & ~st_r.pend;
              st_nxt.loading = 1'b0;
            end
          end
        end
        cfg_load_pkg::CAP_IR: begin
          st_nxt.ir_sh = cfg_load_pkg::IR_CAPTURE;
        end
        cfg_load_pkg::SH_IR: begin
          st_nxt.ir_sh = {st_r.s2.tdi, st_r.ir_sh[cfg_load_pkg::IR_W-1:1]};
        end
        cfg_load_pkg::UPD_IR: begin
          st_nxt.ir = st_r.ir_sh;
          case (st_r.ir_sh)
            cfg_load_pkg::OP_PROGRAM: begin
              st_nxt.abort       = other_load_active;
              st_nxt.loading     = 1'b1;
              st_nxt.interrupted = 1'b0;
              st_nxt.done        = 1'b0;
              st_nxt.overrun     = 1'b0;
              st_nxt.init_cnt    = '0;
              st_nxt.bits        = '0;
            end
            cfg_load_pkg::OP_IO_SETUP: begin
              st_nxt.abort       = 1'b1;
              st_nxt.loading     = 1'b0;
              st_nxt.interrupted = 1'b1;
            end
            cfg_load_pkg::OP_RELOAD: begin
              st_nxt.restart     = 1'b1;
              st_nxt.interrupted = 1'b0;
              st_nxt.done        = 1'b0;
            end
            default: begin
            end
          endcase
        end
        cfg_load_pkg::CAP_DR: begin
          st_nxt.bypass = 1'b0;
          case (op)
            cfg_load_pkg::OP_IDCODE: st_nxt.dr_sh = cfg_load_pkg::ID_VALUE;
            cfg_load_pkg::OP_SAMPLE: st_nxt.dr_sh = cfg_load_pkg::DR_W'(io_pins_in);
            cfg_load_pkg::OP_STATUS: st_nxt.dr_sh = cfg_load_pkg::DR_W'(st_r.done);
            default:                 st_nxt.dr_sh = st_r.dr_sh;
          endcase
        end
        cfg_load_pkg::SH_DR: begin
          case (op)
            cfg_load_pkg::OP_PROGRAM: begin
              st_nxt.word = {st_r.s2.tdi, st_r.word[WORD_W-1:1]};
              st_nxt.bits = st_r.bits + 1'b1;
              word_done   = (st_r.bits == BW'(WORD_W - 1));
            end
            cfg_load_pkg::OP_IDCODE, cfg_load_pkg::OP_SAMPLE,
            cfg_load_pkg::OP_STATUS, cfg_load_pkg::OP_IO_SETUP: begin
              st_nxt.dr_sh = {st_r.s2.tdi, st_r.dr_sh[cfg_load_pkg::DR_W-1:1]};
            end
            default: begin
              st_nxt.bypass = st_r.s2.tdi;
            end
          endcase
        end
        cfg_load_pkg::UPD_DR: begin
          if (op == cfg_load_pkg::OP_IO_SETUP) begin
            st_nxt.io_setup = st_r.dr_sh[cfg_load_pkg::DR_W-1 -: IO_W];
          end
        end
        default: begin
        end
      endcase
    end

    // A word that completes while the last one still waits for room overwrites it, so the waiting word is lost.
    if (word_done) begin
      st_nxt.pend_data = {st_r.s2.tdi, st_r.word[WORD_W-1:1]};
      st_nxt.pend      = 1'b1;
      if (st_r.pend && !fifo_ready) begin
        st_nxt.overrun = 1'b1;
      end
    end

    // bypass bit shows at the following falling edge, half a test clock later.
    if (fall) begin
      st_nxt.tdo_oe_n = 1'b1;
      if (st_r.tap == cfg_load_pkg::SH_IR) begin
        st_nxt.tdo      = st_r.ir_sh[0];
        st_nxt.tdo_oe_n = 1'b0;
      end else if (st_r.tap == cfg_load_pkg::SH_DR) begin
        st_nxt.tdo_oe_n = 1'b0;
        case (op)
          cfg_load_pkg::OP_IDCODE, cfg_load_pkg::OP_SAMPLE,
          cfg_load_pkg::OP_STATUS, cfg_load_pkg::OP_IO_SETUP: st_nxt.tdo = st_r.dr_sh[0];
          cfg_load_pkg::OP_PROGRAM:                           st_nxt.tdo = 1'b0;
          default:                                            st_nxt.tdo = st_r.bypass;
        endcase
      end
    end

    if (st_r.reload_d && !st_r.s2.reload_request_low) begin
      st_nxt.restart     = 1'b1;
      st_nxt.interrupted = 1'b0;
      st_nxt.loading     = 1'b0;
      st_nxt.done        = 1'b0;
    end

    // test reset overrides all
    // The pin is sampled, so the reset lands three system clocks later, with
    // no test clock needed.
    if (!st_r.s2.trst_n) begin
      st_nxt.tap      = cfg_load_pkg::TLR;
      st_nxt.ir       = cfg_load_pkg::OP_IDCODE;
      st_nxt.tdo_oe_n = 1'b1;
    end
  end

  // only resets clear state
  // Global clear and global output enable are deliberately not inputs here.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.s1       <= '1;
      st_r.s2       <= '1;
      st_r.reload_d <= 1'b1;
      st_r.tap      <= cfg_load_pkg::TLR;
      st_r.ir       <= cfg_load_pkg::OP_IDCODE;
      st_r.tdo_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // dedicated test pins
  assign tdo_out            = st_r.tdo;
  assign tdo_oe_n           = st_r.tdo_oe_n;
  assign load_complete_flag = st_r.done;
  // user I/O high-impedance only while a load runs
  assign user_io_hiz        = st_r.loading;
  assign load_abort         = st_r.abort;
  assign restart_load       = st_r.restart;
  assign load_overrun       = st_r.overrun;
  assign io_setup           = st_r.io_setup;
endmodule

//--- verification/cfg_load_port_props.sv
// Concurrent checks on the loader's ports.
`timescale 1ns/1ps
module cfg_load_port_props #(
  parameter int IO_W   = 16,
  parameter int WORD_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic              tck,
  input wire logic              trst_n,
  input wire logic              reload_request_low,
  input wire logic              tdo_out,
  input wire logic              tdo_oe_n,
  input wire logic              load_complete_flag,
  input wire logic              user_io_hiz,
  input wire logic              load_abort,
  input wire logic              restart_load,
  input wire logic [IO_W-1:0]   io_setup,
  input wire logic              cfg_valid,
  input wire logic              cfg_ready,
  input wire logic [WORD_W-1:0] cfg_word
);
  // ----------------------------------------------------------------
  // Cycles since the last test clock edge
  // ----------------------------------------------------------------
  // The ages saturate so a parked clock never wraps into a false edge.
  typedef struct packed {
    logic       tck_q;
    logic [3:0] fall_age;
    logic [3:0] rise_age;
  } age_t;
  age_t st_r;
  age_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.tck_q = tck;
    st_nxt.fall_age = (st_r.tck_q && !tck) ? 4'h0 : st_r.fall_age + {3'h0, &st_r.fall_age == 1'h0};
    st_nxt.rise_age = (!st_r.tck_q && tck) ? 4'h0 : st_r.rise_age + {3'h0, &st_r.rise_age == 1'h0};
    if (!resetn) begin
      st_nxt = '{tck_q: 1'h1, fall_age: 4'hf, rise_age: 4'hf};
    end
  end
  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_tdo_after_fall: assert property (
    $changed(tdo_out) |-> st_r.fall_age <= 4'h6) else $error("data out moved off a fall");
  a_drive_after_fall: assert property (
    $fell(tdo_oe_n) |-> st_r.fall_age <= 4'h6) else $error("data out enabled off a fall");
  a_trst_release: assert property (
    !trst_n [*4] |-> tdo_oe_n) else $error("data out driven in test reset");
  a_setup_on_rise: assert property (
    $changed(io_setup) |-> st_r.rise_age <= 4'h6) else $error("buffer settings off a rise");
  a_reload_pin: assert property (
    $fell(reload_request_low) |-> ##[1:4] restart_load ##1 !load_complete_flag)
    else $error("reload pin did not restart");
  a_abort_pulse: assert property (
    load_abort |=> !load_abort) else $error("abort longer than one cycle");
  a_done_ends_load: assert property (
    $rose(load_complete_flag) |-> $fell(user_io_hiz)) else $error("done without ending load");
  a_word_hold: assert property (
    cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_word)) else $error("word dropped");
endmodule

bind cfg_load_port cfg_load_port_props #(.IO_W(IO_W), .WORD_W(WORD_W)) u_props (
  .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .trst_n(trst_n),
  .reload_request_low(reload_request_low), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
  .load_complete_flag(load_complete_flag), .user_io_hiz(user_io_hiz),
  .load_abort(load_abort), .restart_load(restart_load), .io_setup(io_setup),
  .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_word(cfg_word)
);

//--- verification/cfg_host.sv
// Programmer model that drives the test port as a cable would.
`timescale 1ns/1ps
module cfg_host (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // single device chain
  // A lone device has no peers to bypass and nothing to initialise alongside.
  // board straps
  // Chip select low and scheme select at zero are board straps, not driven here.
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // setup before rise
  // Mode and data are set a half period before each rise.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80;
    tck = 1'h1;
    #40;
    q = tdo;
    #40;
    tck = 1'h0;
  endtask

  task automatic idle(input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      step(1'h0, 1'h1, b);
    end
  endtask

  task automatic tap_reset();
    logic b;
    for (int i = 0; i < 5; i++) begin
      step(1'h1, 1'h1, b);
    end
    step(1'h0, 1'h1, b);
  endtask

  // serial shift
  // Shifts from idle back to idle.
  task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
    logic b;
    q = '0;
    step(1'h1, 1'h1, b);
    if (ir) begin
      step(1'h1, 1'h1, b);
    end
    step(1'h0, 1'h1, b);
    step(1'h0, 1'h1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      q[i] = b;
    end
    step(1'h1, 1'h1, b);
    step(1'h0, 1'h1, b);
    tdi = 1'h1;
  endtask
endmodule

//--- verification/cfg_load_port_tb.sv
// Self-checking bench for the test-port configuration loader.
`timescale 1ns/1ps
module cfg_load_port_tb;
  logic sys_clk, resetn, trst_n, reload_request_low, other_load_active, cfg_ready, stall;
  logic tdo_out, tdo_oe_n, load_complete_flag, user_io_hiz, load_abort, restart_load;
  logic load_overrun, cfg_valid;
  logic [cfg_load_pkg::IO_W-1:0]   io_pins_in, io_setup;
  logic [cfg_load_pkg::WORD_W-1:0] cfg_word, got[$], exp_q[$];
  logic [31:0] q, d;
  wire logic tck, tms, tdi;
  wire logic tdo_pin = tdo_oe_n ? 1'hz : tdo_out;
  int err_count, samples_checked, aborts, restarts;

  cfg_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
  cfg_load_port uut (
    .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .reload_request_low(reload_request_low), .other_load_active(other_load_active),
    .io_pins_in(io_pins_in), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
    .load_complete_flag(load_complete_flag), .user_io_hiz(user_io_hiz),
    .load_abort(load_abort), .restart_load(restart_load), .load_overrun(load_overrun),
    .io_setup(io_setup), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_word(cfg_word)
  );

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (resetn && cfg_valid && cfg_ready) begin
      got.push_back(cfg_word);
    end
    aborts += int'(load_abort === 1'h1);
    restarts += int'(restart_load === 1'h1);
    #1;
    cfg_ready = stall ? 1'h0 : 1'($urandom);
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic ir(input logic [3:0] op);
    logic [31:0] c;
    host.scan(1'h1, cfg_load_pkg::IR_W, {28'h0, op}, c);
    check("ir_capture", c, {28'h0, cfg_load_pkg::IR_CAPTURE});
  endtask

  task automatic dr(input int n, input logic [31:0] v);
    host.scan(1'h0, n, v, q);
  endtask

  initial begin
    #2_000_000;
    err_count++;
    conclude();
  end

  initial begin
    void'($urandom(23));
    {sys_clk, resetn, other_load_active, cfg_ready, stall, err_count, samples_checked} = '0;
    {aborts, restarts, io_pins_in} = '0;
    trst_n = 1'h1;
    reload_request_low = 1'h1;
    repeat (16) @(posedge sys_clk);
    #1;
    resetn = 1'h1;
    #60;
    check("reset_state", {tdo_oe_n, load_complete_flag, user_io_hiz, cfg_valid}, 32'h8);
    host.tap_reset();
    // Another load runs: only identify, sample, I/O setup, program and the reload restart take effect; others act as bypass.
    other_load_active = 1'h1;
    ir(cfg_load_pkg::OP_IDCODE);
    dr(32, '1);
    check("idcode", q, cfg_load_pkg::ID_VALUE);
    io_pins_in = cfg_load_pkg::IO_W'($urandom);
    ir(cfg_load_pkg::OP_SAMPLE);
    dr(cfg_load_pkg::IO_W, '0);
    check("sample", q, 32'(io_pins_in));
    d = $urandom;
    ir(cfg_load_pkg::OP_START);
    dr(16, d);
    check("bypass", q, {16'h0, d[14:0], 1'h0});
    check("bypass_quiet", aborts, 0);
    check("bypass_hiz", user_io_hiz, 0);
    ir(cfg_load_pkg::OP_IO_SETUP);
    check("abort", aborts, 1);
    d = $urandom;
    dr(cfg_load_pkg::IO_W, d);
    check("io_setup", io_setup, 32'(d[15:0]));
    other_load_active = 1'h0;
    ir(cfg_load_pkg::OP_PROGRAM);
    check("hiz_load", {user_io_hiz, load_complete_flag}, 32'h2);
    d = $urandom;
    dr(32, d);
    ir(cfg_load_pkg::OP_START);
    host.idle(cfg_load_pkg::INIT_CYCLES - 1);
    check("done_early", load_complete_flag, 0);
    host.idle(1);
    check("done", {load_complete_flag, user_io_hiz}, 32'h2);
    for (int i = 0; i < 4; i++) begin
      check("word", got[i], 32'(d[8*i +: 8]));
    end
    ir(cfg_load_pkg::OP_STATUS);
    dr(1, '0);
    check("status", q, 1);
    trst_n = 1'h0;
    #100;
    check("trst_oe", tdo_oe_n, 1);
    trst_n = 1'h1;
    #60;
    host.idle(1);
    dr(32, '0);
    check("trst_id", q, cfg_load_pkg::ID_VALUE);
    reload_request_low = 1'h0;
    #100;
    reload_request_low = 1'h1;
    #60;
    check("reload_pin", restarts, 1);
    check("reload_done", load_complete_flag, 0);
    ir(cfg_load_pkg::OP_RELOAD);
    check("reload_op", restarts, 2);
    // Fill the buffer with the drain stalled, then drain it empty.
    got.delete();
    stall = 1'h1;
    ir(cfg_load_pkg::OP_PROGRAM);
    for (int i = 0; i < 9; i++) begin
      d = $urandom;
      for (int j = 0; j < 4; j++) begin
        exp_q.push_back(d[8*j +: 8]);
      end
      dr(i < 8 ? 32 : 16, d);
    end
    check("overrun", {load_overrun, cfg_valid}, 32'h3);
    stall = 1'h0;
    // The 34th word replaced the waiting 33rd, so 33 words drain in all.
    for (int k = 0; k < 400 && got.size() < 33; k++) begin
      @(posedge sys_clk);
    end
    #200;
    check("drained", got.size(), 33);
    check("drained_valid", cfg_valid, 0);
    for (int i = 0; i < 32; i++) begin
      check("fifo_word", got[i], exp_q[i]);
    end
    check("late_word", got[32], exp_q[33]);
    conclude();
  end
endmodule
